// [core/hmu_decode.v]
`timescale 1ns/1ps
`include "hmu_consts.vh"
module hmu_decode
(
   input wire [31:0] instr,
   output reg valid,
   output reg first_hi,
   output reg second_hi,
   output reg first_signed,
   output reg second_signed
);
   wire [4:0] op;
   wire zero_ok;
   assign op = instr[`HMU_OP_HI:`HMU_OP_LO];
   assign zero_ok = (instr[`HMU_ZERO_HI:`HMU_ZERO_LO] == 5'h00);
   always @*
   begin
      // defaults are the all-signed high-by-high case; each op clears what differs
      valid = zero_ok;
      first_hi = 1'h1;
      second_hi = 1'h1;
      first_signed = 1'h1;
      second_signed = 1'h1;
      case (op)
         `HMU_OP_HI_HI_S:
         begin
         end
         `HMU_OP_HI_LO_S:
         begin
            second_hi = 1'h0;
         end
         `HMU_OP_HI_LO_U:
         begin
            second_hi = 1'h0;
            first_signed = 1'h0;
            second_signed = 1'h0;
         end
         `HMU_OP_HI_S_LO_U:
         begin
            second_hi = 1'h0;
            second_signed = 1'h0;
         end
         `HMU_OP_HI_S_HI_U:
         begin
            second_signed = 1'h0;
         end
         `HMU_OP_HI_HI_U:
         begin
            first_signed = 1'h0;
            second_signed = 1'h0;
         end
         `HMU_OP_HI_U_LO_S:
         begin
            second_hi = 1'h0;
            first_signed = 1'h0;
         end
         `HMU_OP_HI_U_HI_S:
         begin
            first_signed = 1'h0;
         end
         `HMU_OP_LO_HI_S:
         begin
            first_hi = 1'h0;
         end
         `HMU_OP_LO_HI_U:
         begin
            first_hi = 1'h0;
            first_signed = 1'h0;
            second_signed = 1'h0;
         end
         `HMU_OP_LO_S_HI_U:
         begin
            first_hi = 1'h0;
            second_signed = 1'h0;
         end
         `HMU_OP_LO_U_HI_S:
         begin
            first_hi = 1'h0;
            first_signed = 1'h0;
         end
         default:
         begin
            valid = 1'h0;
         end
      endcase
   end
endmodule

// [core/hmu_consts.vh]
`ifndef HMU_CONSTS_VH
`define HMU_CONSTS_VH
// instruction word fields
`define HMU_OP_HI 11
`define HMU_OP_LO 7
`define HMU_ZERO_HI 6
`define HMU_ZERO_LO 2
`define HMU_FIRST_HI 17
`define HMU_FIRST_LO 13
`define HMU_SECOND_HI 22
`define HMU_SECOND_LO 18
`define HMU_DST_HI 27
`define HMU_DST_LO 23
`define HMU_XBIT 12
`define HMU_SBIT 1
// operation field codes (only mul_hi_lo_signed is fixed; others chosen)
`define HMU_OP_HI_HI_S 5'h01
`define HMU_OP_HI_LO_S 5'h09
`define HMU_OP_HI_LO_U 5'h0F
`define HMU_OP_HI_S_LO_U 5'h0B
`define HMU_OP_HI_S_HI_U 5'h03
`define HMU_OP_HI_HI_U 5'h07
`define HMU_OP_HI_U_LO_S 5'h0D
`define HMU_OP_HI_U_HI_S 5'h05
`define HMU_OP_LO_HI_S 5'h11
`define HMU_OP_LO_HI_U 5'h17
`define HMU_OP_LO_S_HI_U 5'h13
`define HMU_OP_LO_U_HI_S 5'h15
// pipeline: read in first execute phase, write in second
`define HMU_DELAY_SLOTS 1
`define HMU_NUM_UNITS 2
`endif

// [core/hmu_mul16.v]
`timescale 1ns/1ps
module hmu_mul16
(
   input wire [15:0] a,
   input wire [15:0] b,
   input wire a_signed,
   input wire b_signed,
   output wire [31:0] product
);
   wire signed [16:0] a_ext;
   wire signed [16:0] b_ext;
   wire signed [33:0] full;
   // one extra bit makes a single signed multiplier cover all four sign mixes
   assign a_ext = {a_signed & a[15], a};
   assign b_ext = {b_signed & b[15], b};
   assign full = a_ext * b_ext;
   // the 32-bit product never overflows, so the upper bits are pure sign
   assign product = full[31:0];
endmodule

// [core/hmu_unit.v]
`timescale 1ns/1ps
`include "hmu_consts.vh"
// Notes on behaviour
// - high-by-high signed: upper halves of both sources, signed 32-bit product
// - high-by-low signed: signed upper first source times signed lower second source
// - high-by-low unsigned: both halves unsigned, unsigned 32-bit result
// - high signed by low unsigned, signed result
// - high signed by high unsigned, signed result
// - high-by-high unsigned: both upper halves unsigned, unsigned product
// - high unsigned by low signed, signed result
// - high unsigned by high signed, signed result
// - low-by-high signed: lower first source times upper second, both signed
// - low-by-high unsigned: both halves unsigned, unsigned result
// - low signed by high unsigned, signed result
// - low unsigned by high signed, signed result
// - sources read in first execute phase, destination written in second
// - each operation runs on either multiplier unit, one per register side
// - destination written only when condition is true, else no operation
// - op field 01001 in bits 11..7, bits 6..2 zero, is signed high-by-low
module hmu_unit
#(
   parameter NUM_UNITS = `HMU_NUM_UNITS
)
(
   input wire clk,
   input wire rst,
   input wire [NUM_UNITS-1:0] issue,
   input wire [NUM_UNITS-1:0] cond_true,
   input wire [32*NUM_UNITS-1:0] instr,
   input wire [32*NUM_UNITS-1:0] first_source,
   input wire [32*NUM_UNITS-1:0] second_source,
   output wire [NUM_UNITS-1:0] illegal,
   output wire [NUM_UNITS-1:0] wr_en,
   output wire [5*NUM_UNITS-1:0] wr_addr,
   output wire [32*NUM_UNITS-1:0] wr_data
);
   genvar u;
   generate
      for (u = 0; u < NUM_UNITS; u = u + 1)
      begin : unit
         wire [31:0] ins;
         wire [31:0] s1;
         wire [31:0] s2;
         wire dec_valid;
         wire s1_hi;
         wire s2_hi;
         wire s1_sg;
         wire s2_sg;
         wire [15:0] op_a;
         wire [15:0] op_b;
         wire [31:0] prod;
         wire go;
         reg en_reg;
         reg [4:0] addr_reg;
         reg [31:0] data_reg;
         assign ins = instr[32*u+31:32*u];
         assign s1 = first_source[32*u+31:32*u];
         assign s2 = second_source[32*u+31:32*u];
         hmu_decode dec
         (
            .instr(ins),
            .valid(dec_valid),
            .first_hi(s1_hi),
            .second_hi(s2_hi),
            .first_signed(s1_sg),
            .second_signed(s2_sg)
         );
         // halves picked in the issue cycle, the first execute phase
         assign op_a = s1_hi ? s1[31:16] : s1[15:0];
         assign op_b = s2_hi ? s2[31:16] : s2[15:0];
         hmu_mul16 mul
         (
            .a(op_a),
            .b(op_b),
            .a_signed(s1_sg),
            .b_signed(s2_sg),
            .product(prod)
         );
         // undecodable words are flagged and never write
         assign illegal[u] = issue[u] & ~dec_valid;
         assign go = issue[u] & dec_valid & cond_true[u];
         // one register stage: result lands at the next edge, one delay slot
         always @(posedge clk)
         begin
            if (rst)
            begin
               en_reg <= 1'h0;
               addr_reg <= 5'h00;
               data_reg <= 32'h00000000;
            end
            else
            begin
               en_reg <= go;
               // a false condition or a bad word leaves the old result standing
               if (go)
               begin
                  addr_reg <= ins[`HMU_DST_HI:`HMU_DST_LO];
                  data_reg <= prod;
               end
            end
         end
         assign wr_en[u] = en_reg;
         assign wr_addr[5*u+4:5*u] = addr_reg;
         assign wr_data[32*u+31:32*u] = data_reg;
      end
   endgenerate
endmodule

// [test/hmu_chk.sv]
`timescale 1ns/1ps
module hmu_chk
#(
   parameter NUM_UNITS = 2
)
(
   input wire clk,
   input wire rst,
   input wire [NUM_UNITS-1:0] issue,
   input wire [NUM_UNITS-1:0] cond_true,
   input wire [32*NUM_UNITS-1:0] instr,
   input wire [NUM_UNITS-1:0] illegal,
   input wire [NUM_UNITS-1:0] wr_en,
   input wire [5*NUM_UNITS-1:0] wr_addr,
   input wire [32*NUM_UNITS-1:0] wr_data
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_go0; issue[0] && cond_true[0] && !illegal[0]; endsequence
   sequence s_go1; issue[1] && cond_true[1] && !illegal[1]; endsequence
   property p_lat0; s_go0 |=> wr_en[0] && wr_addr[4:0] == $past(instr[27:23]); endproperty
   property p_lat1; s_go1 |=> wr_en[1] && wr_addr[9:5] == $past(instr[59:55]); endproperty
   property p_nop0; issue[0] && !cond_true[0] |=> !wr_en[0]; endproperty
   property p_nop1; !(issue[1] && cond_true[1]) |=> !wr_en[1]; endproperty
   property p_ill0; issue[0] && illegal[0] |=> !wr_en[0]; endproperty
   property p_hold0; !wr_en[0] && !$past(rst) |-> $stable(wr_data[31:0]) && $stable(wr_addr[4:0]); endproperty
   property p_hold1; !wr_en[1] && !$past(rst) |-> $stable(wr_data[63:32]) && $stable(wr_addr[9:5]); endproperty
   property p_dec0; issue[0] && instr[11:7] == 5'h09 && instr[6:2] == 5'h00 |-> !illegal[0]; endproperty
   property p_zero1; issue[1] && instr[38:34] != 5'h00 |-> illegal[1]; endproperty
   a_lat0: assert property (p_lat0) else $error("unit 0 write missing");
   a_lat1: assert property (p_lat1) else $error("unit 1 write missing");
   a_nop0: assert property (p_nop0) else $error("unit 0 wrote on false condition");
   a_nop1: assert property (p_nop1) else $error("unit 1 wrote without cause");
   a_ill0: assert property (p_ill0) else $error("unit 0 wrote illegal op");
   a_hold0: assert property (p_hold0) else $error("unit 0 result moved");
   a_hold1: assert property (p_hold1) else $error("unit 1 result moved");
   a_dec0: assert property (p_dec0) else $error("op 01001 refused");
   a_zero1: assert property (p_zero1) else $error("nonzero low field accepted");
endmodule
bind hmu_unit hmu_chk #(.NUM_UNITS(NUM_UNITS)) u_chk (.clk(clk), .rst(rst), .issue(issue),
   .cond_true(cond_true), .instr(instr), .illegal(illegal), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));

// [test/hmu_rf.sv]
`timescale 1ns/1ps
module hmu_rf
(
   input wire clk,
   input wire [1:0] wr_en,
   input wire [9:0] wr_addr,
   input wire [63:0] wr_data
);
   // one file per side; a unit only writes its own side
   logic [31:0] mem [2][32];
   always @(posedge clk)
      for (int u = 0; u < 2; u++)
         if (wr_en[u])
            mem[u][wr_addr[5*u+:5]] <= wr_data[32*u+:32];
endmodule

// [test/halfword_multiply_unit_test.sv]
`timescale 1ns/1ps
`include "hmu_consts.vh"
module halfword_multiply_unit_test;
   logic clk = 0;
   logic rst = 1;
   logic [1:0] issue = 0, cond_true = 0, illegal, wr_en, exp_en = 0;
   logic [63:0] instr = 0, first_source = 0, second_source = 0, wr_data;
   logic [9:0] wr_addr;
   logic [36:0] exp_v [2];
   logic [4:0] lk;
   logic [36:0] pend [2];
   logic [1:0] pend_en = 0;
   int fails = 0, samples_checked = 0, seed = 32'hc093, r;
   // op code then flags: first hi, second hi, first signed, second signed
   logic [8:0] tbl [12] = '{{`HMU_OP_HI_HI_S, 4'hF}, {`HMU_OP_HI_LO_S, 4'hB}, {`HMU_OP_HI_LO_U, 4'h8},
      {`HMU_OP_HI_S_LO_U, 4'hA}, {`HMU_OP_HI_S_HI_U, 4'hE}, {`HMU_OP_HI_HI_U, 4'hC}, {`HMU_OP_HI_U_LO_S, 4'h9},
      {`HMU_OP_HI_U_HI_S, 4'hD}, {`HMU_OP_LO_HI_S, 4'h7}, {`HMU_OP_LO_HI_U, 4'h4}, {`HMU_OP_LO_S_HI_U, 4'h6},
      {`HMU_OP_LO_U_HI_S, 4'h5}};
   hmu_unit #(.NUM_UNITS(2)) DUT (.clk(clk), .rst(rst), .issue(issue), .cond_true(cond_true), .instr(instr),
      .first_source(first_source), .second_source(second_source), .illegal(illegal), .wr_en(wr_en),
      .wr_addr(wr_addr), .wr_data(wr_data));
   hmu_rf rf (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));
   function automatic logic [4:0] look(input logic [31:0] w);
      look = 5'h00;
      for (int i = 0; i < 12; i++)
         if (tbl[i][8:4] == w[11:7] && w[6:2] == 5'h00)
            look = {1'b1, tbl[i][3:0]};
   endfunction
   function automatic logic [31:0] prod(input logic [3:0] f, input logic [31:0] a, b);
      longint x, y;
      x = f[3] ? a[31:16] : a[15:0];
      y = f[2] ? b[31:16] : b[15:0];
      if (f[1] && x[15])
         x -= 65536;
      if (f[0] && y[15])
         y -= 65536;
      prod = 32'(x * y);
   endfunction
   task chk(input logic [36:0] s, e);
      samples_checked++;
      if (s !== e)
      begin
         fails++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task results;
      $display("checks %0d fails %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
      forever
         #12.5 clk = ~clk;
   // outputs settle by the falling edge; expectation for the next edge is formed here too
   always @(negedge clk)
      for (int u = 0; u < 2; u++)
      begin
         lk = look(instr[32*u+:32]);
         // the unit's own-side file holds last cycle's result once its edge has passed
         if (pend_en[u])
            chk(37'(rf.mem[u][pend[u][36:32]]), 37'(pend[u][31:0]));
         chk(37'(wr_en[u]), 37'(exp_en[u]));
         if (exp_en[u])
            chk({wr_addr[5*u+:5], wr_data[32*u+:32]}, exp_v[u]); // to
         chk(37'(illegal[u]), 37'(issue[u] && !lk[4]));
         pend_en[u] = exp_en[u];
         pend[u] = exp_v[u];
         exp_en[u] = !rst && issue[u] && cond_true[u] && lk[4];
         exp_v[u] = {instr[32*u+23+:5], prod(lk[3:0], first_source[32*u+:32], second_source[32*u+:32])};
      end
   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 0;
      for (int n = 0; n < 3000; n++)
      begin
         @(posedge clk);
         rst <= (n >= 1500 && n < 1502);
         for (int u = 0; u < 2; u++)
         begin
            r = $random(seed);
            instr[32*u+:32] <= {r[31:12], r[9:8] ? tbl[r[3:0] % 12][8:4] : r[16:12], r[11:10] ? 5'h00 : r[6:2], r[1:0]};
            first_source[32*u+:32] <= r[20] ? 32'h8000FFFF : $random(seed);
            second_source[32*u+:32] <= r[22] ? 32'hFFFF8000 : $random(seed);
            issue[u] <= (r[18] | r[19]) && !(n >= 1500 && n < 1503);
            cond_true[u] <= r[17] | r[21];
         end
      end
      @(posedge clk);
      issue <= 0;
      repeat (2) @(posedge clk);
      results;
   end
   initial
   begin
      #(25 * 4000);
      fails++;
      results;
   end
endmodule
